// ==== core/io_port_map.svh ====
`ifndef IO_PORT_MAP_SVH
`define IO_PORT_MAP_SVH

// clock rate of the card controller
`define CLK_HZ 10000000
`define CLK_PERIOD_NS 100

// restart delays as printed, and their cycle counts
`define RESET_WAIT_MS 50
`define POWER_WAIT_MS 80
`define RESET_WAIT_CYCLES (`RESET_WAIT_MS * (`CLK_HZ / 1000))
`define POWER_WAIT_CYCLES (`POWER_WAIT_MS * (`CLK_HZ / 1000))

// interrupt pulse length as printed, and its cycle count
`define IRQ_PULSE_NS 5000
`define IRQ_PULSE_CYCLES (`IRQ_PULSE_NS / `CLK_PERIOD_NS)

// register offsets inside the two-byte window (address bit 0)
`define STATUS_OFFSET 1'h0
`define DATA_OFFSET 1'h1

// status byte layout
`define TX_AVAIL_BIT 7
`define RX_READY_BIT 6
`define STATUS_RESET 8'h00
`define BYTE_RESET 8'h00

`endif

// ==== core/io_port_pkg.sv ====
package io_port_pkg;

	// one byte of the backplane data bus
	typedef logic [7:0] byte_t;

	// restart delay counter, wide enough for the power-on delay
	typedef logic [19:0] wait_cnt_t;

	// interrupt pulse counter
	typedef logic [5:0] irq_cnt_t;

	// restart sequence of the card controller
	typedef enum logic [1:0] {
		seq_power_wait,
		seq_held,
		seq_reset_wait,
		seq_running
	} seq_state_t;

endpackage : io_port_pkg

// ==== core/reset_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "io_port_map.svh"

module reset_sequencer #(
	parameter int RESET_WAIT_CYCLES = `RESET_WAIT_CYCLES,
	parameter int POWER_WAIT_CYCLES = `POWER_WAIT_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic local_reset_jumper,
	output logic ctrl_run
);
	import io_port_pkg::*;

	// last count of each delay, cast to the counter width
	localparam wait_cnt_t RESET_LAST = wait_cnt_t'(RESET_WAIT_CYCLES - 1);
	localparam wait_cnt_t POWER_LAST = wait_cnt_t'(POWER_WAIT_CYCLES - 1);

	seq_state_t state_reg; // where the restart stands
	seq_state_t state_next;
	wait_cnt_t cnt_reg; // cycles spent waiting
	logic counting; // a delay is running

	// next state; the jumper wins over any delay in progress
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			seq_power_wait: begin
				if (local_reset_jumper) begin
					state_next = seq_held;
				end else if (cnt_reg == POWER_LAST) begin
					state_next = seq_running;
				end
			end
			seq_held: begin
				// released only when the contact opens
				if (!local_reset_jumper) begin
					state_next = seq_reset_wait;
				end
			end
			seq_reset_wait: begin
				if (local_reset_jumper) begin
					state_next = seq_held;
				end else if (cnt_reg == RESET_LAST) begin
					state_next = seq_running;
				end
			end
			seq_running: begin
				if (local_reset_jumper) begin
					state_next = seq_held;
				end
			end
			default: begin
				state_next = seq_held;
			end
		endcase
	end

	assign counting = (state_reg == seq_power_wait) || (state_reg == seq_reset_wait);

	// state register; supply monitor restarts the long delay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= seq_power_wait;
		end else begin
			state_reg <= state_next;
		end
	end

	// delay counter, cleared whenever the state changes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (counting && (state_next == state_reg)) begin
			cnt_reg <= cnt_reg + wait_cnt_t'(1);
		end else begin
			cnt_reg <= '0;
		end
	end

	// run level for the controller, from a register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_run <= 1'b0;
		end else begin
			ctrl_run <= (state_next == seq_running);
		end
	end

endmodule : reset_sequencer
`default_nettype wire

// ==== core/backplane_io_slave_port.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "io_port_map.svh"

module backplane_io_slave_port #(
	parameter int RESET_WAIT_CYCLES = `RESET_WAIT_CYCLES,
	parameter int POWER_WAIT_CYCLES = `POWER_WAIT_CYCLES
) (
	input wire logic clk,
	input wire logic nrst, // supply monitor, active low
	input wire logic local_reset_jumper, // 1 = pins shorted
	input wire logic cpu_mode_jumper, // 1 = fitted
	input wire logic irq_route_jumper, // 1 = fitted
	input wire logic cycle_qualify_switch, // 1 = switch ON
	input wire logic [6:0] base_addr_switches, // switches two..eight, 1 = ON
	input wire io_port_pkg::byte_t addr, // backplane address, low byte
	input wire io_port_pkg::byte_t data_in, // backplane data, master driving
	output var io_port_pkg::byte_t data_out, // backplane data, card driving
	output logic data_oe, // card drives the data bus
	input wire logic io_request_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic first_cycle_n,
	output logic int_out_n, // interrupt pin level when driven
	output logic int_oe, // interrupt pin is pulled low
	output logic irq_indicator, // lamp
	output logic ctrl_run, // controller out of reset
	output logic debug_mode, // controller operating mode
	output logic channels_at_min, // all outputs forced to scale bottom
	input wire io_port_pkg::byte_t ctrl_tx_byte, // byte for the master
	input wire logic ctrl_tx_load, // pulse: controller posts a byte
	output var io_port_pkg::byte_t ctrl_rx_byte, // byte from the master
	input wire logic ctrl_rx_take // pulse: controller consumed the byte
);
	import io_port_pkg::*;

	// pulse length and its last count, for logic and checks
	localparam int IRQ_CYCLES = `IRQ_PULSE_CYCLES;
	localparam int IRQ_LAST = IRQ_CYCLES - 1;
	localparam irq_cnt_t IRQ_CNT_LAST = irq_cnt_t'(IRQ_LAST);

	// decode
	logic [6:0] base_bits; // switch levels as address bits
	logic cycle_ok; // machine-cycle qualification passed
	logic window_hit; // address and request match the card
	logic rd_hit; // read strobe inside the window
	logic wr_hit; // write strobe inside the window
	logic data_sel; // A0 points at the data byte
	logic rd_prev_reg; // read strobe seen last cycle
	logic wr_prev_reg; // write strobe seen last cycle
	logic rd_start; // first cycle of a read
	logic wr_start; // first cycle of a write

	// flags and bytes
	logic tx_avail_reg; // byte waiting for the master
	logic rx_ready_reg; // card can take a byte
	logic tx_prev_reg;
	logic rx_prev_reg;
	logic run_prev_reg;
	logic run_start; // first running cycle
	byte_t tx_byte_reg; // outgoing byte
	byte_t status_byte; // assembled status value

	// interrupt
	logic comm_request; // level request
	logic request_event; // a flag just rose
	logic irq_pulse_reg; // pulse in progress
	logic irq_pending_reg; // event seen during a pulse
	irq_cnt_t irq_cnt_reg;

	// restart timing lives in its own module; the backplane reset
	// pin is deliberately not an input at all
	reset_sequencer #(
		.RESET_WAIT_CYCLES(RESET_WAIT_CYCLES),
		.POWER_WAIT_CYCLES(POWER_WAIT_CYCLES)
	) u_seq (
		.clk(clk),
		.nrst(nrst),
		.local_reset_jumper(local_reset_jumper),
		.ctrl_run(ctrl_run)
	);

	// switch ON pulls its line to zero
	assign base_bits = ~base_addr_switches;

	// with qualification on, a cycle with the first-cycle line low
	// is an acknowledge, not an access
	assign cycle_ok = !cycle_qualify_switch || first_cycle_n;

	// A0 is left out of the compare, so the window is two bytes
	// on an even base anywhere in the low 256 bytes
	assign window_hit = (addr[7:1] == base_bits) && !io_request_n && cycle_ok;

	// strobes; a write with read also low is treated as no write
	assign rd_hit = window_hit && !rd_n;
	assign wr_hit = window_hit && !wr_n && rd_n;
	assign data_sel = (addr[0] == `DATA_OFFSET);

	// strobe history, so each access acts once however long it lasts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_prev_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
		end else begin
			rd_prev_reg <= rd_hit;
			wr_prev_reg <= wr_hit;
		end
	end

	assign rd_start = rd_hit && !rd_prev_reg;
	assign wr_start = wr_hit && !wr_prev_reg;

	// run edge, used to present the idle flags
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= ctrl_run;
		end
	end

	assign run_start = ctrl_run && !run_prev_reg;

	// outgoing flag; a new post in the same cycle as the fetch wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_avail_reg <= 1'b0;
		end else if (!ctrl_run || run_start) begin
			tx_avail_reg <= 1'b0;
		end else begin
			tx_avail_reg <= ctrl_tx_load || (tx_avail_reg && !(rd_start && data_sel));
		end
	end

	// ready flag; consumption by the controller wins over a master write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_ready_reg <= 1'b0;
		end else if (!ctrl_run) begin
			rx_ready_reg <= 1'b0; // not ready while held
		end else if (run_start) begin
			rx_ready_reg <= 1'b1;
		end else begin
			rx_ready_reg <= ctrl_rx_take || (rx_ready_reg && !(wr_start && data_sel));
		end
	end

	// outgoing byte, posted by the controller
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_byte_reg <= `BYTE_RESET;
		end else if (ctrl_tx_load) begin
			tx_byte_reg <= ctrl_tx_byte;
		end
	end

	// incoming byte; status writes fall through untouched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_rx_byte <= `BYTE_RESET;
		end else if (wr_start && data_sel) begin
			ctrl_rx_byte <= data_in;
		end
	end

	// status layout; unused bits read zero
	always_comb begin
		status_byte = `STATUS_RESET;
		status_byte[`TX_AVAIL_BIT] = tx_avail_reg;
		status_byte[`RX_READY_BIT] = rx_ready_reg;
	end

	// read path: data and enable from flops, so they move together,
	// one cycle behind the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_out <= `BYTE_RESET;
			data_oe <= 1'b0;
		end else begin
			data_oe <= rd_hit;
			if (data_sel) begin
				data_out <= tx_byte_reg;
			end else begin
				data_out <= status_byte;
			end
		end
	end

	// request level and rising flags
	assign comm_request = tx_avail_reg || rx_ready_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_prev_reg <= 1'b0;
			rx_prev_reg <= 1'b0;
		end else begin
			tx_prev_reg <= tx_avail_reg;
			rx_prev_reg <= rx_ready_reg;
		end
	end

	assign request_event = (tx_avail_reg && !tx_prev_reg) || (rx_ready_reg && !rx_prev_reg);

	// pulse generator; an event during a pulse is kept and fired after,
	// so the master never misses one, at the cost of back-to-back pulses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_pulse_reg <= 1'b0;
			irq_pending_reg <= 1'b0;
			irq_cnt_reg <= '0;
		end else if (irq_pulse_reg) begin
			irq_pending_reg <= irq_pending_reg || request_event;
			if (irq_cnt_reg == IRQ_CNT_LAST) begin
				irq_pulse_reg <= 1'b0;
				irq_cnt_reg <= '0;
			end else begin
				irq_cnt_reg <= irq_cnt_reg + irq_cnt_t'(1);
			end
		end else if (comm_request && (request_event || irq_pending_reg)) begin
			irq_pulse_reg <= 1'b1;
			irq_pending_reg <= 1'b0;
		end else begin
			irq_pending_reg <= 1'b0;
		end
	end

	// open-drain pin: only pulled low, only when routed
	assign int_out_n = 1'b0;
	assign int_oe = irq_pulse_reg && irq_route_jumper;
	assign irq_indicator = irq_pulse_reg;

	// mode taken while held, so it cannot change under a running cpu
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			debug_mode <= 1'b0;
		end else if (!ctrl_run) begin
			debug_mode <= cpu_mode_jumper;
		end
	end

	// outputs parked at scale bottom whenever the controller is down
	assign channels_at_min = !ctrl_run;

	// checks

	a_route_gate: assert property (@(posedge clk) disable iff (!nrst)
		!irq_route_jumper |-> !int_oe)
		else $error("interrupt driven with routing jumper open");

	a_jumper_holds: assert property (@(posedge clk) disable iff (!nrst)
		local_reset_jumper ##1 local_reset_jumper |-> !ctrl_run)
		else $error("controller running with reset jumper shorted");

	a_mode_follow: assert property (@(posedge clk) disable iff (!nrst)
		!ctrl_run && $past(!ctrl_run) |-> debug_mode == $past(cpu_mode_jumper))
		else $error("mode does not follow jumper while held");

	a_qualify_block: assert property (@(posedge clk) disable iff (!nrst)
		cycle_qualify_switch && !first_cycle_n |=> !data_oe)
		else $error("access answered during first machine cycle");

	a_min_while_down: assert property (@(posedge clk) disable iff (!nrst)
		$fell(ctrl_run) |-> channels_at_min[*8])
		else $error("channels not held at scale bottom");

	a_restart_delay: assert property (@(posedge clk) disable iff (!nrst)
		$fell(local_reset_jumper) |-> !ctrl_run[*8])
		else $error("controller restarted too early");

	a_request_pulse: assert property (@(posedge clk) disable iff (!nrst)
		$rose(rx_ready_reg) |-> ##[1:120] irq_pulse_reg)
		else $error("no pulse after ready flag rose");

	// check helper: cycles the pulse has stood so far; kept apart from the
	// generator's own counter, so a wrong limit there still shows up
	logic [6:0] pulse_len_reg;

	// counts while the pulse stands, back to zero once it drops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_len_reg <= '0;
		end else if (irq_pulse_reg) begin
			pulse_len_reg <= pulse_len_reg + 7'(1);
		end else begin
			pulse_len_reg <= '0;
		end
	end

	a_pulse_length: assert property (@(posedge clk) disable iff (!nrst)
		$fell(irq_pulse_reg) |-> pulse_len_reg == 7'(IRQ_CYCLES))
		else $error("interrupt pulse length wrong");

	a_pulse_bound: assert property (@(posedge clk) disable iff (!nrst)
		irq_pulse_reg |-> pulse_len_reg < 7'(IRQ_CYCLES))
		else $error("interrupt pulse overran");

	a_lamp_tracks: assert property (@(posedge clk) disable iff (!nrst)
		irq_route_jumper |-> (int_oe == irq_indicator))
		else $error("lamp and interrupt disagree");

	a_window_match: assert property (@(posedge clk) disable iff (!nrst)
		data_oe |-> $past(addr[7:1]) == $past(~base_addr_switches))
		else $error("answered outside the address window");

	a_status_layout: assert property (@(posedge clk) disable iff (!nrst)
		rd_hit && !data_sel |=> data_out == {$past(tx_avail_reg), $past(rx_ready_reg), 6'h00})
		else $error("status byte layout wrong");

	a_idle_flags: assert property (@(posedge clk) disable iff (!nrst)
		$rose(ctrl_run) |=> rx_ready_reg && !tx_avail_reg)
		else $error("flags not idle after restart");

	a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_run && !run_start && rd_start && data_sel && !ctrl_tx_load |=> !tx_avail_reg)
		else $error("data read left tx flag set");

	a_write_clears: assert property (@(posedge clk) disable iff (!nrst)
		ctrl_run && !run_start && wr_start && data_sel && !ctrl_rx_take
		|=> !rx_ready_reg && ctrl_rx_byte == $past(data_in))
		else $error("data write not taken");

	// a write aimed at the status byte must leave the data byte alone
	a_status_readonly: assert property (@(posedge clk) disable iff (!nrst)
		wr_start && !data_sel |=> ctrl_rx_byte == $past(ctrl_rx_byte))
		else $error("status write changed the data byte");

endmodule : backplane_io_slave_port
`default_nettype wire

// ==== test/backplane_master.sv ====
`timescale 1ns/1ns
`default_nettype none

// master board on the backplane: one byte access at a time
module backplane_master (
	input wire logic clk,
	output var io_port_pkg::byte_t addr, // address a7..a0
	output var io_port_pkg::byte_t data_in, // write data
	output logic io_request_n,
	output logic rd_n,
	output logic wr_n,
	output logic first_cycle_n,
	input wire io_port_pkg::byte_t data_out, // card read data
	input wire logic data_oe // card drives data
);
	import io_port_pkg::*;

	// sole agent on the bus, nothing else in the window
	initial begin
		addr = 8'h00;
		data_in = 8'h00;
		io_request_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		first_cycle_n = 1'b1;
	end

	// released lines show the inverse, not a stale value
	task automatic idle();
		io_request_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		first_cycle_n = 1'b1;
		addr = ~addr;
		data_in = ~data_in;
	endtask : idle

	// read: strobes held two edges, answer taken after the second
	task automatic rd(input byte_t a, input logic m1_n, output byte_t d, output logic oe);
		@(posedge clk);
		#1;
		addr = a;
		first_cycle_n = m1_n; // only the qualification tests drive it low
		io_request_n = 1'b0;
		rd_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		d = data_out;
		oe = data_oe;
		idle();
	endtask : rd

	// write: no answer, strobes held two edges
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk);
		#1;
		addr = a;
		data_in = d;
		io_request_n = 1'b0;
		wr_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		idle();
	endtask : wr
endmodule : backplane_master

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "io_port_map.svh"

module tb_top;
	import io_port_pkg::*;

	localparam int RW = 20; // shortened restart delays
	localparam int PW = 30;
	typedef struct {logic [6:0] sw; byte_t a; logic oe;} row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic local_reset_jumper = 1'b0;
	logic cpu_mode_jumper = 1'b0;
	logic irq_route_jumper = 1'b0;
	logic cycle_qualify_switch = 1'b0;
	logic [6:0] base_addr_switches = 7'h1f;
	byte_t ctrl_tx_byte = 8'h00;
	logic ctrl_tx_load = 1'b0;
	logic ctrl_rx_take = 1'b0;
	byte_t addr, data_in, data_out, ctrl_rx_byte, d;
	logic io_request_n, rd_n, wr_n, first_cycle_n, data_oe, oe;
	logic int_out_n, int_oe, irq_indicator, ctrl_run, debug_mode, channels_at_min;
	int err_count = 0;
	int comparisons = 0;
	int ni, no;
	// status reads: switches, address, card answers
	row_t rows [6] = '{'{7'h1f, 8'hc0, 1'b1}, '{7'h1f, 8'hc2, 1'b0},
		'{7'h1f, 8'h40, 1'b0}, '{7'h7f, 8'h00, 1'b1},
		'{7'h00, 8'hfe, 1'b1}, '{7'h00, 8'hfc, 1'b0}};

	// 10 mhz clock
	always #50 clk = ~clk;

	backplane_io_slave_port #(.RESET_WAIT_CYCLES(RW), .POWER_WAIT_CYCLES(PW))
	u_backplane_io_slave_port (.clk(clk), .nrst(nrst),
		.local_reset_jumper(local_reset_jumper), .cpu_mode_jumper(cpu_mode_jumper),
		.irq_route_jumper(irq_route_jumper), .cycle_qualify_switch(cycle_qualify_switch),
		.base_addr_switches(base_addr_switches), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .io_request_n(io_request_n),
		.rd_n(rd_n), .wr_n(wr_n), .first_cycle_n(first_cycle_n),
		.int_out_n(int_out_n), .int_oe(int_oe), .irq_indicator(irq_indicator),
		.ctrl_run(ctrl_run), .debug_mode(debug_mode), .channels_at_min(channels_at_min),
		.ctrl_tx_byte(ctrl_tx_byte), .ctrl_tx_load(ctrl_tx_load),
		.ctrl_rx_byte(ctrl_rx_byte), .ctrl_rx_take(ctrl_rx_take));

	backplane_master u_backplane_master (.clk(clk), .addr(addr), .data_in(data_in),
		.io_request_n(io_request_n), .rd_n(rd_n), .wr_n(wr_n),
		.first_cycle_n(first_cycle_n), .data_out(data_out), .data_oe(data_oe));

	// one compare, counted
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// inputs move just after the rising edge
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	// bounded wait for the controller to run
	task automatic wait_run();
		int w;
		w = 0;
		while (ctrl_run !== 1'b1 && w < 10) begin
			tick();
			w++;
		end
	endtask : wait_run

	// length of the next pulse on lamp and on pin
	task automatic pulse(output int n_ind, output int n_oe);
		int w;
		w = 0;
		n_ind = 0;
		n_oe = 0;
		while (irq_indicator !== 1'b1 && w < 10) begin
			tick();
			w++;
		end
		while (irq_indicator === 1'b1 && n_ind < 100) begin
			if (int_oe === 1'b1) n_oe++;
			n_ind++;
			tick();
		end
	endtask : pulse

	// a hang counts as a mismatch
	initial begin
		#300000;
		err_count++;
		$display("watchdog expired");
		test_done();
	end

	initial begin
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (PW - 2) tick();
		chk(ctrl_run, 1'b0);
		chk(channels_at_min, 1'b1);
		wait_run();
		chk(ctrl_run, 1'b1);
		pulse(ni, no);
		chk(8'(ni), 8'(`IRQ_PULSE_CYCLES));
		chk(8'(no), 8'h00);
		$display("test power-on done");
		for (int i = 0; i < 6; i++) begin
			base_addr_switches = rows[i].sw;
			u_backplane_master.rd(rows[i].a, 1'b1, d, oe);
			chk(oe, rows[i].oe);
			if (rows[i].oe) chk(d, 8'h40);
		end
		base_addr_switches = 7'h1f;
		$display("test decode table done");
		// byte from the controller, routed interrupt
		irq_route_jumper = 1'b1;
		ctrl_tx_byte = 8'ha5;
		ctrl_tx_load = 1'b1;
		tick();
		ctrl_tx_load = 1'b0;
		pulse(ni, no);
		chk(8'(no), 8'(`IRQ_PULSE_CYCLES));
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(d, 8'hc0);
		u_backplane_master.rd(8'hc1, 1'b1, d, oe);
		chk(d, 8'ha5);
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(d, 8'h40);
		$display("test transmit done");
		// byte to the controller
		u_backplane_master.wr(8'hc1, 8'h5a);
		chk(ctrl_rx_byte, 8'h5a);
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(d, 8'h00);
		ctrl_rx_take = 1'b1;
		tick();
		ctrl_rx_take = 1'b0;
		pulse(ni, no);
		chk(8'(no), 8'(`IRQ_PULSE_CYCLES));
		chk(int_out_n, 1'b0);
		u_backplane_master.wr(8'hc0, 8'hff);
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(d, 8'h40);
		chk(ctrl_rx_byte, 8'h5a);
		$display("test receive done");
		// qualification by the first-cycle signal
		cycle_qualify_switch = 1'b1;
		u_backplane_master.rd(8'hc0, 1'b0, d, oe);
		chk(oe, 1'b0);
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(oe, 1'b1);
		cycle_qualify_switch = 1'b0;
		u_backplane_master.rd(8'hc0, 1'b0, d, oe);
		chk(oe, 1'b1);
		$display("test qualify done");
		// local reset jumper and mode jumper
		cpu_mode_jumper = 1'b1;
		local_reset_jumper = 1'b1;
		repeat (3) tick();
		chk(ctrl_run, 1'b0);
		chk(channels_at_min, 1'b1);
		chk(debug_mode, 1'b1);
		repeat (RW + 5) tick();
		chk(ctrl_run, 1'b0);
		local_reset_jumper = 1'b0;
		repeat (RW - 2) tick();
		chk(ctrl_run, 1'b0);
		wait_run();
		chk(ctrl_run, 1'b1);
		cpu_mode_jumper = 1'b0;
		tick();
		chk(debug_mode, 1'b1);
		u_backplane_master.rd(8'hc0, 1'b1, d, oe);
		chk(d, 8'h40);
		nrst = 1'b0;
		tick();
		chk(ctrl_run, 1'b0);
		chk(debug_mode, 1'b0);
		nrst = 1'b1;
		repeat (PW - 2) tick();
		chk(ctrl_run, 1'b0);
		wait_run();
		chk(ctrl_run, 1'b1);
		$display("test jumpers done");
		test_done();
	end
endmodule : tb_top

`default_nettype wire
